/* hdl/spcr_top.sv */
// Serial master port: bus registers, FIFOs and the serial frame engine.
//
// Notes on behaviour
// - Lane format 0 moves one bit per clock full duplex, 1 two bits, 2 four bits half duplex.
// - A data frame lasts the wide frame size field plus one serial clocks.
// - A control frame lasts the control word size field plus one serial clocks.
// - Direction 0 transmits and receives in the same frames with lane format 0; with dual or quad lanes it only receives.
// - Direction 3 sends the control word first and then receives data frames.
// - The frame count is a 16-bit writable field that resets to zero.
// - Bit 0 of the target select register selects the one target when set.
// - Writing the data window pushes transmit data, reading it pops receive data.
`timescale 1ns/1ps
module spcr_top
  import spcr_pkg::*;
#(
  parameter int DEPTH = spcr_pkg::FIFO_DEPTH
) (
  // System clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spcr_pkg::ADDR_W-1:0] paddr,
  input wire logic [spcr_pkg::DATA_W-1:0] pwdata,
  output logic [spcr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link.
  output logic sclk,
  output logic ss_n,
  output spcr_pkg::spcr_lanes_s lanes_out,
  input wire logic [3:0] lanes_in,
  // Levels and thresholds for the neighbouring status logic.
  output logic [7:0] tx_level_value,
  output logic [7:0] rx_level_value,
  output logic [7:0] tx_threshold_value,
  output logic [7:0] rx_threshold_value
);
  import spcr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LEAD = 3'h1,
    ST_TRAIL = 3'h2,
    ST_GAP = 3'h3
  } spcr_state_e;

  spcr_frame_ctl_s frame_control;
  logic [15:0] frame_count;
  logic port_enable;
  logic [2:0] three_wire_control;
  logic target_select;
  logic [15:0] clock_divisor;
  logic [7:0] tx_threshold;
  logic [7:0] rx_threshold;

  spcr_state_e state;
  logic ctl_phase;
  logic rx_phase;
  logic [16:0] frames_left;
  logic [5:0] clocks_left;
  logic [DATA_W-1:0] sh_tx;
  logic [DATA_W-1:0] sh_rx;
  logic [3:0] in_meta;
  logic [3:0] in_sync;
  logic [3:0] in_bits;
  logic half_tick;

  logic access;
  logic is_data;
  logic tx_push;
  logic tx_ready;
  logic tx_valid;
  logic tx_pop;
  logic [DATA_W-1:0] tx_word;
  logic rx_push;
  logic rx_valid;
  logic rx_pop;
  logic [DATA_W-1:0] rx_word;
  logic [LVL_W-1:0] tx_level;
  logic [LVL_W-1:0] rx_level;
  logic start;
  logic last_clock;
  logic more_tx;
  logic [5:0] data_clocks;
  logic [5:0] ctl_clocks;
  logic [DATA_W-1:0] rd_value;
  logic [1:0] lane_shift;
  logic [7:0] data_bits;
  logic [7:0] ctl_bits;
  logic [DATA_W-1:0] data_load;
  logic [DATA_W-1:0] ctl_load;

  assign access = psel && penable && !pready;
  assign is_data = (paddr >= OFS_DATA_FIRST) && (paddr <= OFS_DATA_LAST) &&
                   (paddr[1:0] == 2'b00);
  assign tx_push = access && pwrite && is_data;
  assign rx_pop = access && !pwrite && is_data && rx_valid;

  assign data_clocks = 6'(frame_control.wide_frame_size) + 6'h01;
  assign ctl_clocks = 6'(frame_control.control_word_size) + 6'h01;
  // Wide lanes carry two or four bits per clock.
  assign lane_shift = (frame_control.lane_format == 2'h3) ? 2'h0 :
                      frame_control.lane_format;
  assign data_bits = 8'(data_clocks) << lane_shift;
  assign ctl_bits = 8'(ctl_clocks) << lane_shift;
  // Frames longer than a word send the word first, then zeros.
  assign data_load = (data_bits > 8'h20) ? tx_word :
                     tx_word << (8'h20 - data_bits);
  assign ctl_load = (ctl_bits > 8'h20) ? tx_word :
                    tx_word << (8'h20 - ctl_bits);

  assign start = port_enable && state == ST_IDLE && tx_valid;
  assign last_clock = state == ST_TRAIL && half_tick && clocks_left == 6'h01;
  // Both directions continue while transmit data is queued.
  assign more_tx = !ctl_phase && !frame_control.direction_mode[1] && tx_valid;
  assign tx_pop = start || (last_clock && more_tx);
  // Receive side only captures in receiving frames.
  assign rx_push = last_clock && rx_phase;

  spcr_fifo #(.W(DATA_W), .DEPTH(DEPTH), .LVL_W(LVL_W)) u_tx_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .flush(!port_enable),
    .wr_valid(tx_push),
    .wr_data(pwdata),
    .wr_ready(tx_ready),
    .rd_valid(tx_valid),
    .rd_ready(tx_pop),
    .rd_data(tx_word),
    .level(tx_level)
  );

  spcr_fifo #(.W(DATA_W), .DEPTH(DEPTH), .LVL_W(LVL_W)) u_rx_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .flush(!port_enable),
    .wr_valid(rx_push),
    .wr_data(sh_rx),
    .wr_ready(),
    .rd_valid(rx_valid),
    .rd_ready(rx_pop),
    .rd_data(rx_word),
    .level(rx_level)
  );

  spcr_clkdiv u_clkdiv (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(port_enable && state != ST_IDLE),
    .divisor(clock_divisor),
    .half_tick(half_tick)
  );

  // Register writes; the fill levels have no write path.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      frame_control <= spcr_frame_ctl_s'(RST_WORD);
      frame_count <= RST_WORD[15:0];
      port_enable <= RST_WORD[0];
      three_wire_control <= RST_WORD[2:0];
      target_select <= RST_WORD[0];
      clock_divisor <= RST_WORD[15:0];
      tx_threshold <= RST_WORD[7:0];
      rx_threshold <= RST_WORD[7:0];
    end else if (access && pwrite) begin
      case (paddr)
        OFS_FRAME_CONTROL: begin
          frame_control <= spcr_frame_ctl_s'(pwdata & FRAME_CONTROL_MASK);
        end
        OFS_FRAME_COUNT_CONTROL: begin
          frame_count <= pwdata[15:0];
        end
        OFS_PORT_ENABLE: begin
          port_enable <= pwdata[0];
        end
        OFS_THREE_WIRE_CONTROL: begin
          three_wire_control <= pwdata[2:0];
        end
        OFS_TARGET_SELECT: begin
          target_select <= pwdata[0];
        end
        OFS_CLOCK_DIVIDER: begin
          clock_divisor <= pwdata[15:0];
        end
        OFS_TX_THRESHOLD: begin
          tx_threshold <= pwdata[7:0];
        end
        OFS_RX_THRESHOLD: begin
          rx_threshold <= pwdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Read multiplexer.
  always_comb begin
    rd_value = RST_WORD;
    case (paddr)
      OFS_FRAME_CONTROL: rd_value = 32'(frame_control) & FRAME_CONTROL_MASK;
      OFS_FRAME_COUNT_CONTROL: rd_value = {16'h0000, frame_count};
      OFS_PORT_ENABLE: rd_value = {31'h0000_0000, port_enable};
      OFS_THREE_WIRE_CONTROL: rd_value = {29'h0000_0000, three_wire_control};
      OFS_TARGET_SELECT: rd_value = {31'h0000_0000, target_select};
      OFS_CLOCK_DIVIDER: rd_value = {16'h0000, clock_divisor};
      OFS_TX_THRESHOLD: rd_value = {24'h00_0000, tx_threshold};
      OFS_RX_THRESHOLD: rd_value = {24'h00_0000, rx_threshold};
      OFS_TX_FILL_LEVEL: rd_value = 32'(tx_level);
      OFS_RX_FILL_LEVEL: rd_value = 32'(rx_level);
      default: begin
        if (is_data && rx_valid) begin
          rd_value = rx_word;
        end
      end
    endcase
  end

  // Bus answer: one wait state, then ready for one cycle.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= RST_WORD;
    end else begin
      pready <= access;
      pslverr <= 1'b0;
      if (access && !pwrite) begin
        prdata <= rd_value;
      end
    end
  end

  // Two-stage synchroniser on the incoming lanes.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      in_meta <= 4'h0;
      in_sync <= 4'h0;
    end else begin
      in_meta <= lanes_in;
      in_sync <= in_meta;
    end
  end

  assign in_bits = frame_control.loopback_test ? lanes_out.data : in_sync;

  // Frame sequencer.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !port_enable) begin
      state <= ST_IDLE;
      ctl_phase <= 1'b0;
      rx_phase <= 1'b0;
      frames_left <= 17'h0_0000;
      clocks_left <= 6'h00;
      sh_tx <= RST_WORD;
      sh_rx <= RST_WORD;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start) begin
            state <= ST_LEAD;
            sh_rx <= RST_WORD;
            sh_tx <= data_load;
            frames_left <= 17'(frame_count);
            case (frame_control.direction_mode)
              DIR_CTL_THEN_RX: begin
                ctl_phase <= 1'b1;
                rx_phase <= 1'b0;
                clocks_left <= ctl_clocks;
                sh_tx <= ctl_load;
              end
              // Received frames triggered by a queued word.
              DIR_RX_ONLY: begin
                ctl_phase <= 1'b0;
                rx_phase <= 1'b1;
                clocks_left <= data_clocks;
              end
              DIR_TX_ONLY: begin
                ctl_phase <= 1'b0;
                rx_phase <= 1'b0;
                clocks_left <= data_clocks;
              end
              default: begin
                ctl_phase <= 1'b0;
                rx_phase <= 1'b1;
                clocks_left <= data_clocks;
              end
            endcase
          end
        end
        ST_LEAD: begin
          if (half_tick) begin
            state <= ST_TRAIL;
            // Capture one, two or four bits per clock.
            case (frame_control.lane_format)
              LANE_DUAL: sh_rx <= {sh_rx[DATA_W-3:0], in_bits[1:0]};
              LANE_QUAD: sh_rx <= {sh_rx[DATA_W-5:0], in_bits};
              default: sh_rx <= {sh_rx[DATA_W-2:0], in_bits[1]};
            endcase
          end
        end
        ST_TRAIL: begin
          if (half_tick) begin
            clocks_left <= 6'(clocks_left - 6'h01);
            state <= ST_LEAD;
            // Shift out one, two or four bits per clock.
            case (frame_control.lane_format)
              LANE_DUAL: sh_tx <= {sh_tx[DATA_W-3:0], 2'b00};
              LANE_QUAD: sh_tx <= {sh_tx[DATA_W-5:0], 4'h0};
              default: sh_tx <= {sh_tx[DATA_W-2:0], 1'b0};
            endcase
            if (clocks_left == 6'h01) begin
              state <= ST_GAP;
              clocks_left <= data_clocks;
              sh_rx <= RST_WORD;
              if (ctl_phase) begin
                // Receiving starts after the control word.
                ctl_phase <= 1'b0;
                rx_phase <= 1'b1;
              end else if (frame_control.direction_mode == DIR_RX_ONLY ||
                           frame_control.direction_mode == DIR_CTL_THEN_RX) begin
                // Frame count plus one frames are received.
                if (frames_left == 17'h0_0000) begin
                  state <= ST_IDLE;
                end
                frames_left <= 17'(frames_left - 17'h0_0001);
              end else if (more_tx) begin
                sh_tx <= data_load;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
        end
        ST_GAP: begin
          if (half_tick) begin
            state <= ST_LEAD;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Serial clock, select and lane drivers.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sclk <= 1'b0;
      ss_n <= 1'b1;
      lanes_out <= '{data: 4'h0, oe_n: 4'hf};
    end else begin
      // Clock toggles on each half-period pulse except the one that ends the gap.
      sclk <= (state == ST_TRAIL) ? !frame_control.clock_polarity
                                  : frame_control.clock_polarity;
      ss_n <= !(target_select && state != ST_IDLE &&
                !(state == ST_GAP && frame_control.select_toggle_en));
      lanes_out.data <= 4'h0;
      lanes_out.oe_n <= 4'hf;
      if (state != ST_IDLE) begin
        // Single lane always drives lane 0; wide lanes drive on send.
        case (frame_control.lane_format)
          LANE_DUAL: begin
            lanes_out.data <= {2'b00, sh_tx[DATA_W-1:DATA_W-2]};
            lanes_out.oe_n <= rx_phase ? 4'hf : 4'hc;
          end
          LANE_QUAD: begin
            lanes_out.data <= sh_tx[DATA_W-1:DATA_W-4];
            lanes_out.oe_n <= rx_phase ? 4'hf : 4'h0;
          end
          default: begin
            lanes_out.data <= {3'b000, sh_tx[DATA_W-1]};
            lanes_out.oe_n <= 4'he;
          end
        endcase
      end
    end
  end

  // Levels and thresholds for neighbouring logic.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_level_value <= 8'h00;
      rx_level_value <= 8'h00;
      tx_threshold_value <= 8'h00;
      rx_threshold_value <= 8'h00;
    end else begin
      // Levels follow every push and pop.
      tx_level_value <= 8'(tx_level);
      rx_level_value <= 8'(rx_level);
      tx_threshold_value <= tx_threshold;
      rx_threshold_value <= rx_threshold;
    end
  end
endmodule : spcr_top

/* hdl/spcr_pkg.sv */
// Shared constants, register map and field layouts of the serial port control block.
package spcr_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int LVL_W = 5;

  localparam logic [ADDR_W-1:0] OFS_FRAME_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FRAME_COUNT_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PORT_ENABLE = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_THREE_WIRE_CONTROL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_TARGET_SELECT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CLOCK_DIVIDER = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_TX_THRESHOLD = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_RX_THRESHOLD = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_TX_FILL_LEVEL = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_RX_FILL_LEVEL = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_DATA_FIRST = 8'h60;
  localparam logic [ADDR_W-1:0] OFS_DATA_LAST = 8'hec;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] FRAME_CONTROL_MASK = 32'h017f_ffff;
  localparam logic [31:0] FRAME_COUNT_MASK = 32'h0000_ffff;
  localparam logic [31:0] PORT_ENABLE_MASK = 32'h0000_0001;
  localparam logic [31:0] THREE_WIRE_MASK = 32'h0000_0007;
  localparam logic [31:0] TARGET_SELECT_MASK = 32'h0000_0001;
  localparam logic [31:0] CLOCK_DIVIDER_MASK = 32'h0000_ffff;
  localparam logic [31:0] THRESHOLD_MASK = 32'h0000_00ff;

  typedef enum logic [1:0] {
    LANE_SINGLE = 2'h0,
    LANE_DUAL = 2'h1,
    LANE_QUAD = 2'h2
  } spcr_lane_e;

  typedef enum logic [1:0] {
    DIR_TX_RX = 2'h0,
    DIR_TX_ONLY = 2'h1,
    DIR_RX_ONLY = 2'h2,
    DIR_CTL_THEN_RX = 2'h3
  } spcr_dir_e;

  typedef struct packed {
    logic [6:0] reserved_hi;
    logic select_toggle_en;
    logic reserved_23;
    logic [1:0] lane_format;
    logic [4:0] wide_frame_size;
    logic [3:0] control_word_size;
    logic loopback_test;
    logic target_output_en;
    logic [1:0] direction_mode;
    logic clock_polarity;
    logic clock_phase;
    logic [1:0] protocol_format;
    logic [3:0] frame_size;
  } spcr_frame_ctl_s;

  typedef struct packed {
    logic [3:0] data;
    logic [3:0] oe_n;
  } spcr_lanes_s;

endpackage : spcr_pkg

/* hdl/spcr_fifo.sv */
// Synchronous FIFO with fill level and flush, used for transmit and receive.
`timescale 1ns/1ps
module spcr_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 16,
  parameter int LVL_W = 5
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic flush,
  // Filling side.
  input wire logic wr_valid,
  input wire logic [W-1:0] wr_data,
  output logic wr_ready,
  // Draining side.
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data,
  // Status.
  output logic [LVL_W-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [LVL_W-1:0] FULL_LVL = LVL_W'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic push;
  logic pop;

  assign wr_ready = (level != FULL_LVL);
  assign rd_valid = (level != '0);
  assign rd_data = mem[rd_ptr];
  assign push = wr_valid && wr_ready;
  assign pop = rd_ready && rd_valid;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr_ptr <= PW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= PW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
        level <= LVL_W'(level + 1'b1);
      end else if (pop && !push) begin
        level <= LVL_W'(level - 1'b1);
      end
    end
  end
endmodule : spcr_fifo

/* hdl/spcr_clkdiv.sv */
// Serial clock divider giving one enable pulse per half serial clock period.
`timescale 1ns/1ps
module spcr_clkdiv (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control.
  input wire logic run,
  input wire logic [15:0] divisor,
  // Half-period enable pulse.
  output logic half_tick
);
  logic [14:0] cnt;
  logic [14:0] half;

  assign half = divisor[15:1];

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !run || half == 15'h0000) begin
      cnt <= 15'h0000;
      half_tick <= 1'b0;
    end else if (cnt == 15'(half - 15'h0001)) begin
      cnt <= 15'h0000;
      half_tick <= 1'b1;
    end else begin
      cnt <= 15'(cnt + 15'h0001);
      half_tick <= 1'b0;
    end
  end
endmodule : spcr_clkdiv

/* tb/spcr_top_chk.sv */
// Concurrent checks on the ports of the serial port control block.
`timescale 1ns/1ps
module spcr_top_chk
  import spcr_pkg::*;
#(
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register bus.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spcr_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Serial link and levels.
  input wire logic sclk,
  input wire logic ss_n,
  input wire spcr_pkg::spcr_lanes_s lanes_out,
  input wire logic [7:0] tx_level_value,
  input wire logic [7:0] rx_level_value
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_ready_wait: assert property (
    psel && penable && !pready |=> pready) else $error("ready late");
  chk_ready_pulse: assert property (
    pready |=> !pready) else $error("ready too long");
  chk_no_error: assert property (!pslverr) else $error("error response");
  chk_rdata_hold: assert property (
    $changed(prdata) |-> pready && !pwrite) else $error("read data moved");
  chk_sclk_high: assert property (
    $rose(sclk) |=> sclk [*3] ##1 !sclk) else $error("high phase length");
  chk_sclk_low: assert property (
    $fell(sclk) && !ss_n |=> !sclk [*3]) else $error("low phase length");
  chk_lead_time: assert property (
    $fell(ss_n) |-> !sclk [*5] ##1 sclk) else $error("lead time");
  chk_clock_select: assert property (
    $rose(sclk) |-> !ss_n) else $error("clock while unselected");
  chk_idle_release: assert property (
    ss_n |-> lanes_out.oe_n == 4'hf) else $error("lanes driven while idle");
  chk_level_step: assert property (
    $changed(rx_level_value) |-> rx_level_value == 8'h00 ||
    rx_level_value == $past(rx_level_value) + 8'h01 ||
    rx_level_value == $past(rx_level_value) - 8'h01) else $error("level jump");
  chk_level_bound: assert property (
    tx_level_value <= DEPTH && rx_level_value <= DEPTH) else $error("level");

  cover property ($fell(ss_n));
  cover property (pready && !pwrite);
  cover property (rx_level_value == 8'h02);
endmodule : spcr_top_chk

bind spcr_top spcr_top_chk #(.DEPTH(DEPTH)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sclk(sclk), .ss_n(ss_n), .lanes_out(lanes_out),
  .tx_level_value(tx_level_value), .rx_level_value(rx_level_value)
);

/* tb/spcr_target_model.sv */
// Behavioural serial target that answers and records the port's frames.
`timescale 1ns/1ps
module spcr_target_model
  import spcr_pkg::*;
#(
  parameter logic [31:0] REPLY = 32'hc35a_96e1
) (
  // Link from the port.
  input wire logic sclk,
  input wire logic ss_n,
  input wire spcr_pkg::spcr_lanes_s lanes_out,
  output logic [3:0] lanes_in,
  // Lane width and observations for the bench.
  input wire logic [2:0] width,
  output logic [31:0] cap1,
  output logic [31:0] cap2,
  output int edges
);
  logic [31:0] shift = 32'h0;
  logic took = 1'b0;

  initial begin
    cap1 = 32'h0;
    cap2 = 32'h0;
    edges = 0;
  end

  // lane use: quad on 3:0, dual on 1:0, single on lane 1.
  always_comb begin
    if (ss_n) begin
      lanes_in = ~shift[31:28];
    end else if (width == 3'h4) begin
      lanes_in = shift[31:28];
    end else if (width == 3'h2) begin
      lanes_in = {~shift[29:28], shift[31:30]};
    end else begin
      lanes_in = {~shift[30:29], shift[31], ~shift[28]};
    end
  end

  always @(negedge ss_n) begin
    shift = REPLY;
  end

  // answer gating: shift only after the port released lane 1.
  always @(posedge sclk) begin
    took <= lanes_out.oe_n[1];
    edges <= edges + 1;
    cap1 <= {cap1[30:0], lanes_out.data[0]};
    cap2 <= {cap2[29:0], lanes_out.data[1:0]};
  end

  always @(negedge sclk) begin
    if (took) begin
      shift = shift << width;
    end
  end
endmodule : spcr_target_model

/* tb/testbench.sv */
// Self-checking bench for the serial port control block.
`timescale 1ns/1ps
module testbench;
  import spcr_pkg::*;
  localparam logic [31:0] REPLY = 32'hc35a_96e1;
  localparam logic [7:0] OFS_TAB [10] = '{OFS_FRAME_CONTROL,
    OFS_FRAME_COUNT_CONTROL, OFS_PORT_ENABLE, OFS_THREE_WIRE_CONTROL,
    OFS_TARGET_SELECT, OFS_CLOCK_DIVIDER, OFS_TX_THRESHOLD, OFS_RX_THRESHOLD,
    OFS_TX_FILL_LEVEL, OFS_RX_FILL_LEVEL};
  localparam logic [31:0] MSK_TAB [10] = '{FRAME_CONTROL_MASK,
    FRAME_COUNT_MASK, PORT_ENABLE_MASK, THREE_WIRE_MASK, TARGET_SELECT_MASK,
    CLOCK_DIVIDER_MASK, THRESHOLD_MASK, THRESHOLD_MASK, 32'h0, 32'h0};
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, sclk, ss_n;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  spcr_lanes_s lanes_out;
  logic [3:0] lanes_in;
  logic [7:0] tx_lvl, rx_lvl, tx_thr, rx_thr;
  logic [2:0] width;
  logic [31:0] cap1, cap2;
  int edges, e0, fail_count, tests_run;

  spcr_top #(.DEPTH(16)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
    .ss_n(ss_n), .lanes_out(lanes_out), .lanes_in(lanes_in),
    .tx_level_value(tx_lvl), .rx_level_value(rx_lvl),
    .tx_threshold_value(tx_thr), .rx_threshold_value(rx_thr));
  spcr_target_model #(.REPLY(REPLY)) target (.sclk(sclk), .ss_n(ss_n),
    .lanes_out(lanes_out), .lanes_in(lanes_in), .width(width),
    .cap1(cap1), .cap2(cap2), .edges(edges));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic wrap_up;
    if (fail_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 8);
    check({31'h0, pready}, 32'h1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic start(input logic [31:0] ctl, input logic [31:0] cnt,
                       input logic [2:0] w);
    apb(1'b1, OFS_PORT_ENABLE, 32'h0);
    apb(1'b1, OFS_FRAME_CONTROL, ctl);
    apb(1'b1, OFS_FRAME_COUNT_CONTROL, cnt);
    apb(1'b1, OFS_CLOCK_DIVIDER, 32'h8);
    apb(1'b1, OFS_TARGET_SELECT, 32'h1);
    width <= w;
    apb(1'b1, OFS_PORT_ENABLE, 32'h1);
    e0 = edges;
  endtask : start

  task automatic finish_burst(input int n_edges);
    int n;
    n = 0;
    while (ss_n !== 1'b0 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    while (ss_n !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (4) @(posedge clk_sys);
    check({31'h0, ss_n}, 32'h1);
    check(32'(edges - e0), 32'(n_edges));
  endtask : finish_burst

  task automatic t_regs;
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, OFS_TAB[i], 32'h0);
      check(rd, RST_WORD);
    end
    apb(1'b0, 8'h28, 32'h0);
    check(rd, 32'h0);
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, OFS_TAB[i], 32'hffff_ff7f);
      apb(1'b0, OFS_TAB[i], 32'h0);
      check(rd, 32'hffff_ff7f & MSK_TAB[i]);
    end
    check({24'h0, tx_thr}, 32'h7f);
    check({24'h0, rx_thr}, 32'h7f);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFS_TAB[i], 32'h0);
    end
  endtask : t_regs

  task automatic t_full_duplex;
    start(32'h0007_0000, 32'h0, 3'h1);
    apb(1'b1, OFS_DATA_FIRST, 32'h0000_00a5);
    apb(1'b1, OFS_DATA_LAST, 32'h0000_005a);
    @(posedge clk_sys);
    check({24'h0, tx_lvl}, 32'h1);
    finish_burst(16);
    check({16'h0, cap1[15:0]}, 32'ha55a);
    apb(1'b1, OFS_RX_FILL_LEVEL, 32'h7);
    apb(1'b0, OFS_RX_FILL_LEVEL, 32'h0);
    check(rd, 32'h2);
    apb(1'b0, OFS_DATA_FIRST, 32'h0);
    check(rd, {24'h0, REPLY[31:24]});
    apb(1'b0, OFS_RX_FILL_LEVEL, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, OFS_DATA_LAST, 32'h0);
    check(rd, {24'h0, REPLY[23:16]});
    apb(1'b0, OFS_DATA_FIRST, 32'h0);
    check(rd, 32'h0);
  endtask : t_full_duplex

  task automatic t_wide_modes;
    // wide lanes: one-way modes only with dual or quad format.
    start(32'h0023_0100, 32'h0, 3'h2);
    apb(1'b1, OFS_DATA_FIRST, 32'h0000_003c);
    finish_burst(4);
    check({24'h0, cap2[7:0]}, 32'h3c);
    apb(1'b0, OFS_RX_FILL_LEVEL, 32'h0);
    check(rd, 32'h0);
    start(32'h0041_0200, 32'h1, 3'h4);
    apb(1'b1, OFS_DATA_FIRST, 32'h0);
    finish_burst(4);
    apb(1'b0, OFS_RX_FILL_LEVEL, 32'h0);
    check(rd, 32'h2);
    apb(1'b0, OFS_DATA_FIRST, 32'h0);
    check(rd, {24'h0, REPLY[31:24]});
    apb(1'b0, OFS_DATA_FIRST, 32'h0);
    check(rd, {24'h0, REPLY[23:16]});
  endtask : t_wide_modes

  task automatic t_control_then_rx;
    start(32'h0023_3300, 32'h0, 3'h2);
    apb(1'b1, OFS_DATA_FIRST, 32'h0000_0096);
    finish_burst(8);
    check({24'h0, cap2[15:8]}, 32'h96);
    apb(1'b0, OFS_DATA_FIRST, 32'h0);
    check(rd, {24'h0, REPLY[31:24]});
    apb(1'b1, OFS_PORT_ENABLE, 32'h0);
    apb(1'b1, OFS_DATA_FIRST, 32'h1234_5678);
    apb(1'b0, OFS_TX_FILL_LEVEL, 32'h0);
    check(rd, 32'h0);
  endtask : t_control_then_rx

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    width = 3'h1;
    fail_count = 0;
    tests_run = 0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_full_duplex();
    t_wide_modes();
    t_control_then_rx();
    wrap_up();
  end

  initial begin
    repeat (30000) @(posedge clk_sys);
    fail_count++;
    wrap_up();
  end
endmodule : testbench
